// >>> logic/mpof_blink.sv
`timescale 1ns/1ps
`include "mpof_defines.svh"
module mpof_blink
    import mpof_pkg::*;
#(
    parameter int unsigned MS_CYCLES = `MPOF_MS_CYCLES,
    parameter int unsigned HALF_MS   = `MPOF_BLINK_HALF_MS
)(
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic clk_en,
    output logic      ms_tick,
    output logic      blink
);
    if (MS_CYCLES < 1 || HALF_MS < 1) begin : g_chk
        $error("mpof_blink: counts must be at least one");
    end

    logic [31:0] cyc_q, cyc_d;
    logic [31:0] half_q, half_d;
    logic        blink_q, blink_d;

    assign ms_tick = clk_en && (cyc_q == 32'(MS_CYCLES - 1));
    assign blink   = blink_q;

    always_comb begin
        cyc_d   = ms_tick ? 32'h0 : cyc_q + 32'h1;
        half_d  = half_q;
        blink_d = blink_q;
        if (ms_tick) begin
            if (half_q == 32'(HALF_MS - 1)) begin
                half_d  = 32'h0;
                blink_d = !blink_q;
            end else begin
                half_d = half_q + 32'h1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cyc_q   <= 32'h0;
            half_q  <= 32'h0;
            blink_q <= 1'b1;
        end else if (clk_en) begin
            cyc_q   <= cyc_d;
            half_q  <= half_d;
            blink_q <= blink_d;
        end
    end
endmodule : mpof_blink

// >>> logic/mpof_defines.svh
`ifndef MPOF_DEFINES_SVH
`define MPOF_DEFINES_SVH
// Overview of operation
// R1: Inside the range the IO-Link value is a signed count from -2500 at the cable limit to +2500 at the head limit.
// R2: One count stands for 10 um of piston travel, so the value is linear in position.
// R3: Beyond the range the IO-Link value becomes +32760 or -32760, after the side that was left.
// R4: A field too weak to measure gives the IO-Link value 32764.
// R5: Out-of-range indication is always on for both outputs and nothing can switch it off.
// R6: Inside the range the analog level runs linearly from 0 V to 10 V across the span.
// R7: Outside the range the analog level is one of two fixed levels, 11 V or 10.5 V.
// R8: Positions towards the head are positive and towards the cable negative, 25 mm each way from zero.
// R9: In standard I/O mode the yellow indicator is lit inside the range and dark outside it.
// R10: In standard I/O mode the green indicator is steadily lit while powered.
// R11: With IO-Link active the green indicator flashes and the yellow one has no function.
// R12: Neither indicator ever shows a fault pattern.
// R13: Over IO-Link up to eight switching points each detect one piston position.
// R14: Over IO-Link the device records stroke, cycle, dwell and travel times, velocity, field, counts and hours.
// R15: A weak field outranks the out-of-range saturation codes on IO-Link.
// R16: In-range positions are rounded to the nearest count and clamped to the limits before saturation is applied.

// position scaling (micrometres in, counts out)
`define MPOF_POS_LIMIT_UM    19'h061a8
`define MPOF_UM_PER_COUNT    19'h0000a
`define MPOF_UM_HALF_COUNT   19'h00005
`define MPOF_COUNT_LIMIT     16'h09c4
`define MPOF_SAT_POS_CODE    16'h7ff8
`define MPOF_SAT_NEG_CODE    16'h8008
`define MPOF_WEAK_CODE       16'h7ffc

// analog command in millivolts
`define MPOF_MV_PER_COUNT    2
`define MPOF_ANALOG_FULL_MV  14'h2710
`define MPOF_ANALOG_HEAD_MV  14'h2af8
`define MPOF_ANALOG_CABLE_MV 14'h2904

// timing
`define MPOF_CLK_HZ          20000000
`define MPOF_TICK_TIME_US    1000
`define MPOF_MS_CYCLES       (`MPOF_CLK_HZ / 1000000 * `MPOF_TICK_TIME_US)
`define MPOF_BLINK_HALF_MS   500
`define MPOF_VEL_WINDOW_MS   1000
`define MPOF_HOUR_MS         3600000
`define MPOF_NUM_SP          8
`define MPOF_SP_HYST         5
`endif

// >>> logic/mpof_formatter.sv
`timescale 1ns/1ps
`include "mpof_defines.svh"
module mpof_formatter
    import mpof_pkg::*;
#(
    parameter int unsigned MS_CYCLES = `MPOF_MS_CYCLES,
    parameter int unsigned BLINK_MS  = `MPOF_BLINK_HALF_MS,
    parameter int unsigned VEL_MS    = `MPOF_VEL_WINDOW_MS,
    parameter int unsigned HOUR_MS   = `MPOF_HOUR_MS,
    parameter int unsigned NUM_SP    = `MPOF_NUM_SP,
    parameter int unsigned SP_HYST   = `MPOF_SP_HYST
)(
    input  wire logic                 sys_clk,
    input  wire logic                 rst_n,
    input  wire logic                 clk_en,
    input  wire logic                 meas_valid,
    input  wire logic signed [17:0]   meas_pos_um,
    input  wire logic                 field_ok,
    input  wire logic [15:0]          field_strength,
    input  wire logic                 iol_active_pin,
    input  wire logic [NUM_SP-1:0]    sp_enable,
    input  wire logic [NUM_SP*16-1:0] sp_pos_flat,
    input  wire logic [15:0]          pwr_cycles_nv,
    output mpof_count_t               iol_pos,
    output logic                      iol_pos_valid,
    output mpof_mv_t                  dac_mv,
    output logic                      range_indicator,
    output logic                      power_indicator,
    output logic [NUM_SP-1:0]         sp_hit,
    output logic [15:0]               diag_stroke,
    output logic [31:0]               diag_cycle_ms,
    output logic [31:0]               diag_dwell_ms,
    output logic [31:0]               diag_travel_ms,
    output logic [31:0]               diag_velocity,
    output logic [15:0]               diag_field_now,
    output logic [15:0]               diag_field_peak,
    output logic [31:0]               diag_cycle_count,
    output logic [31:0]               diag_distance,
    output logic [31:0]               diag_hours,
    output logic [15:0]               diag_power_cycles
);
    if (NUM_SP < 1 || NUM_SP > 8 || VEL_MS < 1 || HOUR_MS < 1 || SP_HYST > 2500) begin : g_chk
        $error("mpof_formatter: parameter out of supported range");
    end

    // iol_active comes from the transceiver pin: two flops before use
    logic iol_meta_q, iol_sync_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            iol_meta_q <= 1'b0;
            iol_sync_q <= 1'b0;
        end else if (clk_en) begin
            iol_meta_q <= iol_active_pin;
            iol_sync_q <= iol_meta_q;
        end
    end

    logic ms_tick, blink;
    mpof_blink #(
        .MS_CYCLES (MS_CYCLES),
        .HALF_MS   (BLINK_MS)
    ) u_blink (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .ms_tick (ms_tick),
        .blink   (blink)
    );

    // conversion: round half away from zero, then clamp
    logic              neg_c, over_c;
    logic [18:0]       abs_um_c, round_c;
    logic [15:0]       mag_c;
    mpof_count_t       count_c;
    always_comb begin
        neg_c    = meas_pos_um[17];
        abs_um_c = neg_c ? 19'(-{meas_pos_um[17], meas_pos_um}) : 19'({1'b0, meas_pos_um});
        over_c   = abs_um_c > `MPOF_POS_LIMIT_UM;
        round_c  = (abs_um_c + `MPOF_UM_HALF_COUNT) / `MPOF_UM_PER_COUNT; // R2 R16
        mag_c    = (round_c > 19'(`MPOF_COUNT_LIMIT)) ? `MPOF_COUNT_LIMIT : round_c[15:0]; // R16
        count_c  = neg_c ? mpof_count_t'(-mag_c) : mpof_count_t'(mag_c); // R1 R8
    end

    // output group
    mpof_count_t pos_q, pos_d;
    mpof_mv_t    mv_q, mv_d;
    logic        pv_q, pv_d, inr_q, inr_d;
    always_comb begin
        pos_d = pos_q;
        mv_d  = mv_q;
        inr_d = inr_q;
        pv_d  = meas_valid;
        if (meas_valid) begin
            inr_d = field_ok && !over_c;
            // out-of-range handling has no enable: it is always applied  R5
            if (!field_ok) begin
                pos_d = `MPOF_WEAK_CODE; // R4 R15
                mv_d  = `MPOF_ANALOG_HEAD_MV; // R7
            end else if (over_c) begin
                pos_d = neg_c ? `MPOF_SAT_NEG_CODE : `MPOF_SAT_POS_CODE; // R3
                mv_d  = neg_c ? `MPOF_ANALOG_CABLE_MV : `MPOF_ANALOG_HEAD_MV; // R7
            end else begin
                pos_d = count_c; // R1
                mv_d  = 14'((count_c + 16'sd2500) * `MPOF_MV_PER_COUNT); // R6
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pos_q <= 16'h0000;
            mv_q  <= 14'h0000;
            pv_q  <= 1'b0;
            inr_q <= 1'b0;
        end else if (clk_en) begin
            pos_q <= pos_d;
            mv_q  <= mv_d;
            pv_q  <= pv_d;
            inr_q <= inr_d;
        end
    end

    assign iol_pos       = pos_q;
    assign dac_mv        = mv_q;
    assign iol_pos_valid = pv_q && clk_en;

    // indicators carry no fault meaning at all  R12
    assign range_indicator = !iol_sync_q && inr_q; // R9 R11
    assign power_indicator = iol_sync_q ? blink : 1'b1; // R10 R11

    // switching points only work while IO-Link is up
    logic [NUM_SP-1:0] hit_d, hit_q;
    for (genvar i = 0; i < NUM_SP; i++) begin : g_sp
        logic signed [16:0] diff;
        assign diff     = 17'(count_c) - 17'($signed(sp_pos_flat[i*16 +: 16]));
        assign hit_d[i] = (meas_valid && iol_sync_q) ? (sp_enable[i] && field_ok && !over_c && // R13
                          diff <= $signed(17'(SP_HYST)) && diff >= -$signed(17'(SP_HYST))) : (hit_q[i] && iol_sync_q);
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hit_q <= '0;
        end else if (clk_en) begin
            hit_q <= hit_d;
        end
    end
    assign sp_hit = hit_q;

    // actuator diagnostics; a cycle ends at the lower turning point
    logic               sample_ok, have_q, have_d;
    mpof_count_t        last_q, last_d, max_q, max_d, min_q, min_d;
    mpof_dir_e          dir_q, dir_d;
    logic signed [16:0] delta;
    logic [15:0]        adelta;
    logic               mov_q, mov_d;
    logic [31:0]        cyc_q, cyc_d, dwl_q, dwl_d, trv_q, trv_d;
    logic [31:0]        win_q, win_d, vms_q, vms_d, hms_q, hms_d;
    logic [15:0]        stroke_q, stroke_d, fnow_q, fnow_d, fpk_q, fpk_d, pwc_q, pwc_d;
    logic [31:0]        pcyc_q, pcyc_d, pdwl_q, pdwl_d, ptrv_q, ptrv_d, vel_q, vel_d;
    logic [31:0]        ccnt_q, ccnt_d, dist_q, dist_d, hrs_q, hrs_d;
    logic               pwl_q, pwl_d;

    assign sample_ok = meas_valid && field_ok && !over_c;

    always_comb begin
        {have_d, last_d, max_d, min_d, mov_d} = {have_q, last_q, max_q, min_q, mov_q};
        dir_d  = dir_q;
        {cyc_d, dwl_d, trv_d, win_d, vms_d, hms_d} = {cyc_q, dwl_q, trv_q, win_q, vms_q, hms_q};
        {stroke_d, pcyc_d, pdwl_d, ptrv_d, vel_d} = {stroke_q, pcyc_q, pdwl_q, ptrv_q, vel_q};
        {ccnt_d, dist_d, hrs_d, fnow_d, fpk_d} = {ccnt_q, dist_q, hrs_q, fnow_q, fpk_q};
        pwc_d  = pwc_q;
        pwl_d  = 1'b1;
        delta  = 17'(count_c) - 17'(last_q);
        adelta = delta[16] ? 16'(-delta) : 16'(delta);
        // power cycle count taken once, just after reset release
        if (!pwl_q) begin
            pwc_d = pwr_cycles_nv + 16'h0001; // R14
        end
        if (ms_tick) begin
            cyc_d = cyc_q + 32'h1;
            if (mov_q) begin
                trv_d = trv_q + 32'h1;
            end else begin
                dwl_d = dwl_q + 32'h1;
            end
            if (vms_q == 32'(VEL_MS - 1)) begin
                vms_d = 32'h0;
                vel_d = win_q; // R14
                win_d = 32'h0;
            end else begin
                vms_d = vms_q + 32'h1;
            end
            if (hms_q == 32'(HOUR_MS - 1)) begin
                hms_d = 32'h0;
                hrs_d = hrs_q + 32'h1; // R14
            end else begin
                hms_d = hms_q + 32'h1;
            end
        end
        if (meas_valid) begin
            fnow_d = field_strength;
            if (field_strength > fpk_q) begin
                fpk_d = field_strength; // R14
            end
        end
        if (sample_ok) begin
            have_d = 1'b1;
            last_d = count_c;
            if (!have_q) begin
                max_d = count_c;
                min_d = count_c;
            end else begin
                mov_d  = delta != 17'sd0;
                dist_d = dist_q + 32'(adelta); // R14
                win_d  = win_d + 32'(adelta);
                if (count_c > max_q) max_d = count_c;
                if (count_c < min_q) min_d = count_c;
                if (delta > 17'sd0) dir_d = DIR_UP;
                else if (delta < 17'sd0) dir_d = DIR_DOWN;
                if (dir_q == DIR_DOWN && delta > 17'sd0) begin
                    stroke_d = 16'(max_q - min_q); // R14
                    pcyc_d   = cyc_d;
                    pdwl_d   = dwl_d;
                    ptrv_d   = trv_d;
                    ccnt_d   = ccnt_q + 32'h1;
                    cyc_d    = 32'h0;
                    dwl_d    = 32'h0;
                    trv_d    = 32'h0;
                    max_d    = count_c;
                    min_d    = count_c;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            {have_q, mov_q, pwl_q} <= 3'h0;
            {last_q, max_q, min_q} <= 48'h0;
            dir_q <= DIR_STILL;
            {cyc_q, dwl_q, trv_q, win_q, vms_q, hms_q} <= 192'h0;
            {stroke_q, fnow_q, fpk_q, pwc_q} <= 64'h0;
            {pcyc_q, pdwl_q, ptrv_q, vel_q} <= 128'h0;
            {ccnt_q, dist_q, hrs_q} <= 96'h0;
        end else if (clk_en) begin
            {have_q, mov_q, pwl_q} <= {have_d, mov_d, pwl_d};
            {last_q, max_q, min_q} <= {last_d, max_d, min_d};
            dir_q <= dir_d;
            {cyc_q, dwl_q, trv_q, win_q, vms_q, hms_q} <= {cyc_d, dwl_d, trv_d, win_d, vms_d, hms_d};
            {stroke_q, fnow_q, fpk_q, pwc_q} <= {stroke_d, fnow_d, fpk_d, pwc_d};
            {pcyc_q, pdwl_q, ptrv_q, vel_q} <= {pcyc_d, pdwl_d, ptrv_d, vel_d};
            {ccnt_q, dist_q, hrs_q} <= {ccnt_d, dist_d, hrs_d};
        end
    end

    assign diag_stroke       = stroke_q;
    assign diag_cycle_ms     = pcyc_q;
    assign diag_dwell_ms     = pdwl_q;
    assign diag_travel_ms    = ptrv_q;
    assign diag_velocity     = vel_q;
    assign diag_field_now    = fnow_q;
    assign diag_field_peak   = fpk_q;
    assign diag_cycle_count  = ccnt_q;
    assign diag_distance     = dist_q;
    assign diag_hours        = hrs_q;
    assign diag_power_cycles = pwc_q;

    // checks
    weak_code_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R4
        clk_en && meas_valid && !field_ok |=> iol_pos == `MPOF_WEAK_CODE && dac_mv == `MPOF_ANALOG_HEAD_MV)
        else $error("weak field did not give the invalid code");
    sat_code_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R3
        clk_en && meas_valid && field_ok && over_c |=>
        iol_pos == ($past(neg_c) ? `MPOF_SAT_NEG_CODE : `MPOF_SAT_POS_CODE))
        else $error("saturation code wrong after leaving range");
    count_span_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R1
        clk_en && sample_ok |=> $signed(iol_pos) <= 16'sd2500 && $signed(iol_pos) >= -16'sd2500)
        else $error("in-range count outside span");
    count_scale_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R2
        clk_en && sample_ok |=> ($signed(iol_pos) * 10 - $past(meas_pos_um)) <= 5 &&
        ($signed(iol_pos) * 10 - $past(meas_pos_um)) >= -5)
        else $error("count does not match ten micrometres per step");
    sign_side_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R8
        clk_en && sample_ok && meas_pos_um < -18'sd5 |=> $signed(iol_pos) < 16'sd0)
        else $error("cable side position not negative");
    analog_map_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R6
        clk_en && sample_ok |=> ($signed({1'b0, dac_mv}) * 5 - 25000 - $past(meas_pos_um)) <= 5 &&
        ($signed({1'b0, dac_mv}) * 5 - 25000 - $past(meas_pos_um)) >= -5 && dac_mv <= `MPOF_ANALOG_FULL_MV)
        else $error("analog level not proportional");
    analog_over_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R7
        clk_en && meas_valid && field_ok && over_c |=> dac_mv > `MPOF_ANALOG_FULL_MV)
        else $error("analog out-of-range level missing");
    yellow_sio_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R9
        clk_en && meas_valid |=> iol_sync_q || range_indicator == $past(field_ok && !over_c))
        else $error("range indicator wrong in standard mode");
    green_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R10
        !iol_sync_q |-> power_indicator)
        else $error("power indicator not steady");
    iol_leds_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R11
        iol_sync_q |-> !range_indicator && power_indicator == blink)
        else $error("indicators wrong while link active");
    sp_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R13
        clk_en && !iol_sync_q |=> sp_hit == '0)
        else $error("switching point active without link");
endmodule : mpof_formatter

// >>> logic/mpof_pkg.sv
package mpof_pkg;
    typedef logic signed [15:0] mpof_count_t;
    typedef logic [13:0]        mpof_mv_t;
    typedef enum logic [1:0] {
        DIR_STILL,
        DIR_UP,
        DIR_DOWN
    } mpof_dir_e;
endpackage : mpof_pkg

// >>> tb/magnet_position_output_formatter_test.sv
`timescale 1ns/1ps
module magnet_position_output_formatter_test
    import mpof_pkg::*;
;
    logic sys_clk, rst_n, clk_en, meas_valid, field_ok, link_req, iol_active_pin;
    logic signed [17:0] meas_pos_um;
    logic [15:0]        field_strength, pwr_cycles_nv, rx_count;
    logic [7:0]         sp_enable, sp_hit;
    logic [127:0]       sp_pos_flat;
    mpof_count_t        iol_pos, last_pos;
    mpof_mv_t           dac_mv, last_mv;
    logic               iol_pos_valid, range_indicator, power_indicator;
    logic [31:0]        diag_cycle_count, diag_cycle_ms, diag_dwell_ms, diag_travel_ms;
    logic [31:0]        diag_velocity, diag_distance, diag_hours;
    logic [15:0]        diag_field_now, diag_power_cycles, diag_stroke, diag_field_peak;
    int                 bad_count = 0;
    int                 tests_run = 0;

    mpof_formatter #(.MS_CYCLES(4), .BLINK_MS(2), .VEL_MS(3), .HOUR_MS(5)) dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .meas_valid(meas_valid),
        .meas_pos_um(meas_pos_um), .field_ok(field_ok), .field_strength(field_strength),
        .iol_active_pin(iol_active_pin), .sp_enable(sp_enable), .sp_pos_flat(sp_pos_flat),
        .pwr_cycles_nv(pwr_cycles_nv), .iol_pos(iol_pos), .iol_pos_valid(iol_pos_valid),
        .dac_mv(dac_mv), .range_indicator(range_indicator), .power_indicator(power_indicator),
        .sp_hit(sp_hit), .diag_stroke(diag_stroke), .diag_cycle_ms(diag_cycle_ms),
        .diag_dwell_ms(diag_dwell_ms), .diag_travel_ms(diag_travel_ms),
        .diag_velocity(diag_velocity), .diag_field_now(diag_field_now), .diag_field_peak(diag_field_peak),
        .diag_cycle_count(diag_cycle_count), .diag_distance(diag_distance), .diag_hours(diag_hours),
        .diag_power_cycles(diag_power_cycles));

    mpof_master_model master (
        .sys_clk(sys_clk), .rst_n(rst_n), .link_req(link_req), .iol_pos(iol_pos),
        .iol_pos_valid(iol_pos_valid), .dac_mv(dac_mv), .iol_active_pin(iol_active_pin),
        .last_pos(last_pos), .last_mv(last_mv), .rx_count(rx_count));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic conclude;
        $display("checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [15:0] exp_pos(input int um, input bit ok);
        int c;
        if (!ok) return 16'h7ffc;
        if (um > 32'sh61a8) return 16'h7ff8;
        if (um < -32'sh61a8) return 16'h8008;
        // half away from zero, so -5 um and +5 um land symmetrically
        c = (um >= 0) ? (um + 5) / 10 : -((5 - um) / 10);
        if (c > 32'sh9c4) c = 32'sh9c4;
        if (c < -32'sh9c4) c = -32'sh9c4;
        return c[15:0];
    endfunction : exp_pos

    function automatic logic [31:0] exp_mv(input int um, input bit ok);
        int c;
        if (!ok || um > 32'sh61a8) return 32'h2af8;
        if (um < -32'sh61a8) return 32'h2904;
        c = int'(signed'(exp_pos(um, 1'b1)));
        return (c + 32'sh9c4) * 2;
    endfunction : exp_mv

    task automatic smp(input int um, input bit ok);
        logic [15:0] e;
        e = exp_pos(um, ok);
        @(negedge sys_clk);
        meas_valid  = 1'b1;
        meas_pos_um = um[17:0];
        field_ok    = ok;
        @(negedge sys_clk);
        meas_valid = 1'b0;
        check({31'h0, iol_pos_valid}, 32'h1);
        check({16'h0, iol_pos}, {16'h0, e});
        check({18'h0, dac_mv}, exp_mv(um, ok));
        @(negedge sys_clk);
        check({31'h0, iol_pos_valid}, 32'h0);
        check({16'h0, last_pos}, {16'h0, e});
        check({18'h0, last_mv}, exp_mv(um, ok));
    endtask : smp

    task automatic t_reset_diag;
        check({31'h0, power_indicator}, 32'h1);
        check({31'h0, range_indicator}, 32'h0);
        field_strength = 16'h0123;
        smp(0, 1'b1);
        smp(32'sh3e8, 1'b1);
        smp(32'sh1f4, 1'b1);
        check(diag_cycle_count, 32'h0);
        smp(32'sh320, 1'b1);
        check(diag_cycle_count, 32'h1);
        check({16'h0, diag_field_now}, 32'h0123);
        check({16'h0, diag_power_cycles}, 32'h0042);
        // counts 0, 100, 50, 80: one cycle of two ms ticks, one still and one moving
        check({16'h0, diag_stroke}, 32'h64);
        check({16'h0, diag_field_peak}, 32'h0123);
        check(diag_distance, 32'hb4);
        check(diag_velocity, 32'hb4);
        check(diag_cycle_ms, 32'h2);
        check(diag_dwell_ms, 32'h1);
        check(diag_travel_ms, 32'h1);
    endtask : t_reset_diag

    task automatic t_scale;
        int tab[9] = '{32'sh0, 32'sh3039, -32'sh3039, 32'sh61a8, -32'sh61a8, 32'sh5, -32'sh5, 32'sh61a7, 32'sh4};
        foreach (tab[i]) begin
            smp(tab[i], 1'b1);
            check({31'h0, range_indicator}, 32'h1);
            check({31'h0, power_indicator}, 32'h1);
        end
        // 39 edges since reset: five ms ticks make one hour, the second is due at edge 40
        check(diag_hours, 32'h1);
    endtask : t_scale

    task automatic t_freeze;
        @(negedge sys_clk);
        clk_en      = 1'b0;
        meas_valid  = 1'b1;
        meas_pos_um = 18'h03039;
        @(negedge sys_clk);
        meas_valid = 1'b0;
        check({31'h0, iol_pos_valid}, 32'h0);
        check({16'h0, iol_pos}, 32'h7ffc);
        clk_en = 1'b1;
    endtask : t_freeze

    task automatic t_out_of_range;
        int tab[3] = '{32'sh61a9, -32'sh61a9, 32'sh7530};
        foreach (tab[i]) begin
            smp(tab[i], 1'b1);
            check({31'h0, range_indicator}, 32'h0);
            check({31'h0, power_indicator}, 32'h1);
        end
        smp(0, 1'b0);
        check({31'h0, range_indicator}, 32'h0);
        smp(32'sh7530, 1'b0);
        smp(-32'sh7530, 1'b0);
    endtask : t_out_of_range

    task automatic t_link;
        int toggles;
        int dark;
        logic prev;
        @(negedge sys_clk);
        link_req = 1'b1;
        repeat (5) @(negedge sys_clk);
        smp(0, 1'b1);
        check({31'h0, range_indicator}, 32'h0);
        toggles = 0;
        prev = power_indicator;
        // blink half period is 2 ms of 4 cycles, so 64 cycles hold about 8 toggles
        repeat (64) begin
            @(negedge sys_clk);
            if (power_indicator !== prev) toggles++;
            prev = power_indicator;
        end
        check({31'h0, toggles >= 7 && toggles <= 9}, 32'h1);
        sp_enable = 8'h01;
        sp_pos_flat[15:0] = 16'h0064;
        sp_pos_flat[31:16] = 16'h0064;
        smp(32'sh3e8, 1'b1);
        check({24'h0, sp_hit}, 32'h01);
        smp(32'sh44c, 1'b1);
        check({24'h0, sp_hit}, 32'h00);
        // below the point: a distance of minus four counts must still hit
        smp(32'sh3c0, 1'b1);
        repeat (3) @(negedge sys_clk);
        check({24'h0, sp_hit}, 32'h01);
        link_req = 1'b0;
        repeat (5) @(negedge sys_clk);
        check({24'h0, sp_hit}, 32'h00);
        dark = 0;
        repeat (16) begin
            @(negedge sys_clk);
            if (power_indicator !== 1'b1) dark++;
        end
        check(dark, 32'h0);
        smp(0, 1'b1);
        check({31'h0, range_indicator}, 32'h1);
    endtask : t_link

    initial begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        meas_valid = 1'b0;
        meas_pos_um = 18'h00000;
        field_ok = 1'b1;
        field_strength = 16'h0000;
        link_req = 1'b0;
        sp_enable = 8'h00;
        sp_pos_flat = 128'h0;
        pwr_cycles_nv = 16'h0041;
        repeat (20) @(negedge sys_clk);
        rst_n = 1'b1;
        t_reset_diag();
        t_scale();
        t_out_of_range();
        t_freeze();
        t_link();
        conclude();
    end

    // whole run is well under 1000 cycles; 5000 leaves ample margin
    initial begin
        #250000;
        bad_count++;
        conclude();
    end
endmodule : magnet_position_output_formatter_test

// >>> tb/mpof_master_model.sv
`timescale 1ns/1ps
module mpof_master_model
    import mpof_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        link_req,
    input  wire mpof_count_t iol_pos,
    input  wire logic        iol_pos_valid,
    input  wire mpof_mv_t    dac_mv,
    output logic             iol_active_pin,
    output mpof_count_t      last_pos,
    output mpof_mv_t         last_mv,
    output logic [15:0]      rx_count
);
    // the master only sees a value in the one cycle that valid stands, like a real cyclic read
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            iol_active_pin <= 1'b0;
            last_pos       <= 16'h0000;
            last_mv        <= 14'h0000;
            rx_count       <= 16'h0000;
        end else begin
            // session start comes just after an edge, never mid-cycle
            iol_active_pin <= link_req;
            if (iol_pos_valid) begin
                last_pos <= iol_pos;
                last_mv  <= dac_mv;
                rx_count <= rx_count + 16'h0001;
            end
        end
    end
endmodule : mpof_master_model
